/* File: shared/urx_map.svh */
// urx_map.svh: constants of the serial receiver (rates, sample points,
// frame sizes, reset values).
// assumes: included by bare name from design files; definitions only.
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

// samples per bit, normal and double speed
`define URX_OSR_NORMAL 5'h10
`define URX_OSR_DOUBLE 5'h08

// first of the three centre samples used for the vote
`define URX_VOTE_NORMAL 5'h08
`define URX_VOTE_DOUBLE 5'h04

// distance from first to last vote sample
`define URX_VOTE_SPAN 5'h02

// sample number given to the first low sample of a start bit
`define URX_FIRST_SAMPLE 5'h01

// character size code that selects nine data bits
`define URX_CHSZ_NINE 3'h7
`define URX_NINE_BITS 4'h9
`define URX_MIN_BITS 4'h5

// buffer depth and levels
`define URX_BUF_FULL 2'h2

// reset values
`define URX_LINE_IDLE 1'h1
`define URX_CNT_IDLE 5'h00

`endif

/* File: shared/urx_pkg.sv */
// urx_pkg: types shared by the serial receiver and its buffer.
// assumes: compiled before every design file.
package urx_pkg;

   // receiver sequencer states
   typedef enum logic [2:0] {
      URX_IDLE,
      URX_START,
      URX_DATA,
      URX_PARITY,
      URX_STOP
   } urx_state_e;

   // configuration bits held by software elsewhere
   typedef struct packed {
      logic receiver_enable;
      logic double_speed_select;
      logic parity_enable_bit;
      logic parity_odd_select;
      logic stop_bit_count_select;
      logic [2:0] char_size;
      logic rx_complete_irq_enable;
      logic global_irq_enable;
   } urx_cfg_s;

   // one buffered character with its status
   typedef struct packed {
      logic [7:0] data;
      logic received_ninth_bit;
      logic frame_error_flag;
      logic overrun_flag;
      logic parity_error_flag;
   } urx_entry_s;

endpackage

/* File: verilog/urx_fifo2.sv */
// urx_fifo2: two-entry receive buffer, head entry held in a register.
// assumes: single clock; flush empties it in one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "urx_map.svh"

module urx_fifo2 (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic flush,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire urx_pkg::urx_entry_s in_entry,
   // draining side
   input wire logic out_ready,
   output logic out_valid,
   output urx_pkg::urx_entry_s out_entry,
   output logic [1:0] level
);
   import urx_pkg::*;

   urx_entry_s slot [0:1];
   urx_entry_s next_slot [0:1];
   logic [1:0] next_level;
   logic do_push;
   logic do_pop;
   logic wr_idx;

   // handshakes; full refuses new words, so the source must hold them
   assign in_ready = (level != `URX_BUF_FULL) && !flush;
   assign out_valid = (level != 2'h0);
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready && !flush;
   assign out_entry = slot[0];

   // pop shifts the tail forward, push fills the first free slot
   always_comb begin
      next_level = level;
      for (int i = 0; i < 2; i++) begin
         next_slot[i] = slot[i];
      end
      wr_idx = 1'h0;
      if (do_pop) begin
         next_slot[0] = slot[1];
         next_level = level - 2'h1;
      end
      if (do_push) begin
         wr_idx = next_level[0];
         next_slot[wr_idx] = in_entry;
         next_level = next_level + 2'h1;
      end
      if (flush) begin
         next_level = 2'h0;
      end
   end

   // registers only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level <= 2'h0;
         slot[0] <= '0;
         slot[1] <= '0;
      end else begin
         level <= next_level;
         slot[0] <= next_slot[0];
         slot[1] <= next_slot[1];
      end
   end

endmodule
`default_nettype wire

/* File: verilog/urx_receiver.sv */
// urx_receiver: receive side of a serial port: start detection,
// majority-vote data recovery, parity check, two-entry buffer, status.
// assumes: sample_tick pulses at 16x (8x double speed) baud, same clock.
`timescale 1ns/1ns
`default_nettype none
`include "urx_map.svh"

// Functional notes
// - complete flag is one exactly while the buffer holds unread data.
// - clearing receiver enable flushes the buffer, complete flag drops.
// - interrupt requested while flag, its enable and global enable are set.
// - a data read pops one character; handlers must read to clear.
// - error flags travel with their character; read status before data.
// - software writes to error flag positions have no effect.
// - no error flag drives any interrupt.
// - frame error shows the first stop bit of the head character.
// - only the first stop bit is checked, whatever the stop count.
// - overrun when buffer full, shifter waiting, and a new start seen.
// - overrun clears when a frame moves from shifter into buffer.
// - parity error reads zero while parity checking is off.
// - upper parity bit enables checking, lower picks odd or even.
// - parity of data compared with parity bit, result stored with data.
// - parity error set only if checking was on when received.
// - disable stops at once, drops frame, flushes, releases the pin.
// - sampling runs at 16x baud, or 8x in double speed.
// - first low sample is 1; start voted on 8,9,10 or 4,5,6.
// - two or more high validation samples reject the start as noise.
// - bit phase realigns on every valid start bit.
// - 16 or 8 states per bit; bits by vote of three centre samples.
// - stop bit voted alike; a low stop sets frame error.
// - the frame moves to the buffer at the first stop bit.
// - unused upper data bits of short frames read zero.
module urx_receiver (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // configuration and sample rate
   input wire urx_pkg::urx_cfg_s cfg,
   input wire logic sample_tick,
   // software access
   input wire logic data_read,
   // serial pin
   input wire logic rxd_pin,
   output logic rxd_override,
   // status and data
   output logic rx_complete_flag,
   output logic frame_error_flag,
   output logic overrun_flag,
   output logic parity_error_flag,
   output logic received_ninth_bit,
   output logic [7:0] serial_data_register,
   output logic rx_complete_irq
);
   import urx_pkg::*;

   // pin synchroniser
   logic line_s1;
   logic line_s2;

   // sequencer state
   urx_state_e state;
   urx_state_e next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [3:0] bit_idx;
   logic [3:0] next_bit_idx;
   logic [8:0] shreg;
   logic [8:0] next_shreg;
   logic [1:0] votes;
   logic [1:0] next_votes;
   logic last_smp;
   logic next_last_smp;
   logic par_bit;
   logic next_par_bit;

   // completed frame waiting for buffer room
   urx_entry_s pend;
   urx_entry_s next_pend;
   logic pend_vld;
   logic next_pend_vld;
   logic ovr;
   logic next_ovr;

   // derived values
   logic [4:0] osr;
   logic [4:0] vote_last;
   logic [3:0] nbits;
   logic [4:0] cnt_inc;
   logic vote;
   logic at_vote;
   logic at_end;
   logic start_det;
   logic done;
   logic ovr_set;
   logic xfer;
   urx_entry_s frame;
   urx_entry_s push_entry;

   // buffer side
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [1:0] fifo_level;
   urx_entry_s head;

   // two flops before anything looks at the pin
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         line_s1 <= `URX_LINE_IDLE;
         line_s2 <= `URX_LINE_IDLE;
      end else begin
         line_s1 <= rxd_pin;
         line_s2 <= line_s1;
      end
   end

   // rate and frame size; later stop bits are never looked at
   assign osr = cfg.double_speed_select ? `URX_OSR_DOUBLE
                                        : `URX_OSR_NORMAL;
   assign vote_last = (cfg.double_speed_select ? `URX_VOTE_DOUBLE
                       : `URX_VOTE_NORMAL) + `URX_VOTE_SPAN;
   assign nbits = (cfg.char_size == `URX_CHSZ_NINE) ? `URX_NINE_BITS
                  : ({2'h0, cfg.char_size[1:0]} + `URX_MIN_BITS);
   assign cnt_inc = cnt + 5'h01;
   assign at_end = sample_tick && (cnt == osr);
   assign at_vote = sample_tick && !at_end && (cnt_inc == vote_last);

   // majority of the three centre samples, newest from the pin
   assign vote = (votes[1] & votes[0]) | (votes[1] & line_s2)
                 | (votes[0] & line_s2);

   // idle-high to low transition seen on a sample tick
   assign start_det = sample_tick && (state == URX_IDLE) && last_smp
                      && !line_s2 && cfg.receiver_enable;

   // full buffer, frame waiting, new start: data is being lost
   assign ovr_set = start_det && pend_vld && !fifo_in_ready;
   assign done = at_vote && (state == URX_STOP);
   assign xfer = pend_vld && fifo_in_ready;

   // shifter cleared at start, so short frames read zero above
   always_comb begin
      frame = '0;
      frame.data = shreg[7:0];
      frame.received_ninth_bit = shreg[8];
      frame.frame_error_flag = !vote;
      frame.parity_error_flag = cfg.parity_enable_bit
         & (^shreg ^ par_bit ^ cfg.parity_odd_select);
      push_entry = pend;
      push_entry.overrun_flag = ovr;
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_bit_idx = bit_idx;
      next_shreg = shreg;
      next_votes = votes;
      next_last_smp = last_smp;
      next_par_bit = par_bit;
      if (sample_tick) begin
         next_last_smp = line_s2;
         next_votes = {votes[0], line_s2};
      end
      unique case (state)
         URX_IDLE: begin
            next_cnt = `URX_CNT_IDLE;
            if (start_det) begin
               next_state = URX_START;
               next_cnt = `URX_FIRST_SAMPLE;
               next_shreg = '0;
               next_bit_idx = 4'h0;
            end
         end
         URX_START: begin
            if (at_vote && vote) begin
               next_state = URX_IDLE; // noise spike
               next_cnt = `URX_CNT_IDLE;
            end else if (at_end) begin
               next_state = URX_DATA; // phase set by this start
               next_cnt = `URX_FIRST_SAMPLE;
            end else if (sample_tick) begin
               next_cnt = cnt_inc;
            end
         end
         URX_DATA: begin
            if (at_vote) begin
               next_shreg[bit_idx] = vote;
            end
            if (at_end) begin
               next_cnt = `URX_FIRST_SAMPLE;
               if (bit_idx == nbits - 4'h1) begin
                  next_state = cfg.parity_enable_bit ? URX_PARITY
                                                     : URX_STOP;
               end else begin
                  next_bit_idx = bit_idx + 4'h1;
               end
            end else if (sample_tick) begin
               next_cnt = cnt_inc;
            end
         end
         URX_PARITY: begin
            if (at_vote) begin
               next_par_bit = vote;
            end
            if (at_end) begin
               next_state = URX_STOP;
               next_cnt = `URX_FIRST_SAMPLE;
            end else if (sample_tick) begin
               next_cnt = cnt_inc;
            end
         end
         URX_STOP: begin
            // finish right after the vote so an early start is seen
            if (done) begin
               next_state = URX_IDLE;
               next_cnt = `URX_CNT_IDLE;
            end else if (sample_tick) begin
               next_cnt = cnt_inc;
            end
         end
      endcase
      if (!cfg.receiver_enable) begin
         next_state = URX_IDLE; // frame in progress dropped
         next_cnt = `URX_CNT_IDLE;
         next_last_smp = `URX_LINE_IDLE;
      end
   end

   // sequencer registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= URX_IDLE;
         cnt <= `URX_CNT_IDLE;
         bit_idx <= 4'h0;
         shreg <= 9'h000;
         votes <= 2'h3;
         last_smp <= `URX_LINE_IDLE;
         par_bit <= 1'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         bit_idx <= next_bit_idx;
         shreg <= next_shreg;
         votes <= next_votes;
         last_smp <= next_last_smp;
         par_bit <= next_par_bit;
      end
   end

   // held frame; one finishing while it still waits is the lost one
   always_comb begin
      next_pend = pend;
      next_pend_vld = pend_vld;
      if (xfer) begin
         next_pend_vld = 1'h0;
      end
      if (done && (!pend_vld || xfer)) begin
         next_pend = frame;
         next_pend_vld = 1'h1;
      end
      // a set in the same cycle as the clear wins
      next_ovr = (ovr && !xfer) || ovr_set;
      if (!cfg.receiver_enable) begin
         next_pend_vld = 1'h0;
         next_ovr = 1'h0;
      end
   end

   // waiting frame registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend <= '0;
         pend_vld <= 1'h0;
         ovr <= 1'h0;
      end else begin
         pend <= next_pend;
         pend_vld <= next_pend_vld;
         ovr <= next_ovr;
      end
   end

   // receive buffer; a read pops, disable flushes
   urx_fifo2 u_buf (
      .clock(clock),
      .rst(rst),
      .flush(!cfg.receiver_enable),
      .in_valid(pend_vld),
      .in_ready(fifo_in_ready),
      .in_entry(push_entry),
      .out_ready(data_read),
      .out_valid(fifo_out_valid),
      .out_entry(head),
      .level(fifo_level)
   );

   // head entry status; no write path, so writes cannot touch it
   assign rx_complete_flag = fifo_out_valid;
   assign frame_error_flag = fifo_out_valid && head.frame_error_flag;
   assign overrun_flag = fifo_out_valid && head.overrun_flag;
   assign parity_error_flag = fifo_out_valid && cfg.parity_enable_bit
                              && head.parity_error_flag;
   assign received_ninth_bit = head.received_ninth_bit;
   assign serial_data_register = head.data;
   assign rxd_override = cfg.receiver_enable;

   // only the complete flag reaches the interrupt line
   assign rx_complete_irq = rx_complete_flag && cfg.rx_complete_irq_enable
                            && cfg.global_irq_enable;

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_PUSH_FLAG: assert property (
      xfer |=> rx_complete_flag)
      else $error("buffer write did not raise the complete flag");
   AST_DISABLE_FLUSH: assert property (
      !cfg.receiver_enable |=> !rx_complete_flag && !pend_vld)
      else $error("disable did not flush the buffer");
   // the gates may drop in the next cycle, so the request follows them
   AST_IRQ_HOLDS: assert property (
      rx_complete_flag && cfg.rx_complete_irq_enable
      && cfg.global_irq_enable && !data_read && cfg.receiver_enable
      |=> rx_complete_flag && rx_complete_irq == (cfg.global_irq_enable
      && cfg.rx_complete_irq_enable))
      else $error("interrupt dropped while flag still set");
   AST_READ_POPS: assert property (
      data_read && fifo_out_valid && !xfer && cfg.receiver_enable
      |=> fifo_level == $past(fifo_level) - 2'h1)
      else $error("data read did not pop one entry");
   AST_ERR_NO_IRQ: assert property (
      rx_complete_irq |-> rx_complete_flag)
      else $error("interrupt without complete flag");
   AST_STOP_FE: assert property (
      done && !vote && !pend_vld && cfg.receiver_enable |=> pend_vld
      && pend.frame_error_flag)
      else $error("low stop bit did not mark frame error");
   AST_PAR_OFF: assert property (
      done && !cfg.parity_enable_bit && !pend_vld
      |=> !pend.parity_error_flag)
      else $error("parity error stored with checking off");
   AST_OVR_SET: assert property (
      ovr_set |=> ovr ##1 (ovr || $past(xfer) || $past(!cfg.receiver_enable)))
      else $error("overrun not flagged on lost frame");
   AST_OVR_CLR: assert property (
      xfer && !ovr_set && cfg.receiver_enable |=> !ovr)
      else $error("overrun not cleared by transfer");
   AST_NOISE_REJECT: assert property (
      state == URX_START && at_vote && vote && cfg.receiver_enable
      |=> state == URX_IDLE && cnt == `URX_CNT_IDLE)
      else $error("noisy start bit not rejected");
   AST_IDLE_COUNT: assert property (
      state == URX_IDLE |-> cnt == `URX_CNT_IDLE)
      else $error("sample counter moved while idle");
   AST_START_FIRST: assert property (
      start_det |=> state == URX_START && cnt == `URX_FIRST_SAMPLE)
      else $error("start not numbered as sample one");
   COV_FRAME: cover property (done && vote);
   COV_NOISE: cover property (state == URX_START && at_vote && vote);
   COV_OVERRUN: cover property (ovr_set);
   COV_FULL: cover property (fifo_level == `URX_BUF_FULL && data_read);

endmodule
`default_nettype wire

/* File: dv/urx_tx_model.sv */
// urx_tx_model: remote serial transmitter driving the receive line.
// assumes: sample_tick from the bench; a bit lasts ticks_per_bit ticks.
`timescale 1ns/1ns
`default_nettype none

module urx_tx_model (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic sample_tick,
   // frame request, bits sent lsb first
   input wire logic go,
   input wire logic [15:0] frame_bits,
   input wire logic [3:0] frame_len,
   input wire logic [4:0] ticks_per_bit,
   // serial line
   output logic line,
   output logic busy
);
   logic [15:0] shift;
   logic [3:0] left;
   logic [4:0] cnt;

   // line rests high between frames, so a start is a clean falling edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         line <= 1'h1;
         busy <= 1'h0;
         shift <= 16'hFFFF;
         left <= 4'h0;
         cnt <= 5'h00;
      end else if (go && !busy) begin
         shift <= frame_bits;
         left <= frame_len;
         cnt <= ticks_per_bit;
         busy <= 1'h1;
         line <= frame_bits[0];
      end else if (busy && sample_tick) begin
         if (cnt == 5'h01) begin
            cnt <= ticks_per_bit;
            if (left == 4'h1) begin
               busy <= 1'h0;
               line <= 1'h1;
            end else begin
               shift <= shift >> 1;
               line <= shift[1];
               left <= left - 4'h1;
            end
         end else begin
            cnt <= cnt - 5'h01;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/uart_receiver_status_and_start_detect_bench.sv */
// bench for urx_receiver: glitch, then table of frames, overrun, disable.
// assumes: urx_tx_model drives the pin; sample tick every 4 clocks.
`timescale 1ns/1ns
`default_nettype none
`include "urx_map.svh"

module uart_receiver_status_and_start_detect_bench;
   import urx_pkg::*;
   typedef struct packed {
      logic dbl, pen, odd, two;
      logic [2:0] csz;
      logic [8:0] d;
      logic st1, bad;
      logic [7:0] x_data;
      logic x_nin, x_fe, x_pe;
   } urx_row_s;
   logic clock = 1'h0, rst = 1'h1, sample_tick = 1'h0, data_read = 1'h0;
   logic go = 1'h0, tx_busy, rxd_pin, rxd_override, rx_complete_irq;
   logic rx_complete_flag, frame_error_flag, overrun_flag;
   logic parity_error_flag, received_ninth_bit;
   logic [7:0] serial_data_register;
   logic [15:0] bits = 16'hFFFF;
   logic [3:0] len = 4'h1;
   logic [4:0] tpb = `URX_OSR_NORMAL;
   logic [1:0] tick_div = 2'h0;
   urx_cfg_s cfg = '0;
   int fails = 0, cmp_count = 0, cycles = 0;
   urx_row_s rows [7] = '{
      '{0,0,0,0,3'h3,9'h0A5,1,0,8'hA5,0,0,0},
      '{0,0,0,0,3'h0,9'h0FF,1,0,8'h1F,0,0,0},
      '{1,1,0,0,3'h7,9'h13C,1,0,8'h3C,1,0,0},
      '{0,1,1,0,3'h2,9'h055,1,1,8'h55,0,0,1},
      '{0,1,1,0,3'h3,9'h081,1,0,8'h81,0,0,0},
      '{0,0,0,1,3'h3,9'h066,0,0,8'h66,0,1,0},
      '{1,1,0,0,3'h1,9'h0C9,1,1,8'h09,0,0,1}};

   urx_receiver dut (.clock(clock), .rst(rst), .cfg(cfg),
      .sample_tick(sample_tick), .data_read(data_read), .rxd_pin(rxd_pin),
      .rxd_override(rxd_override), .rx_complete_flag(rx_complete_flag),
      .frame_error_flag(frame_error_flag), .overrun_flag(overrun_flag),
      .parity_error_flag(parity_error_flag),
      .received_ninth_bit(received_ninth_bit),
      .serial_data_register(serial_data_register),
      .rx_complete_irq(rx_complete_irq));
   urx_tx_model tx (.clock(clock), .rst(rst), .sample_tick(sample_tick),
      .go(go), .frame_bits(bits), .frame_len(len), .ticks_per_bit(tpb),
      .line(rxd_pin), .busy(tx_busy));

   // 100 MHz clock and a one-cycle sample tick every fourth clock
   always #5 clock = ~clock;
   always @(negedge clock) begin
      tick_div <= tick_div + 2'h1;
      sample_tick <= (tick_div == 2'h3);
   end
   // a hang costs a mismatch; the tests need about 9000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         end_sim();
      end
   end

   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_byte(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock);
   endtask
   // bounded waits, so a stuck flag ends in a mismatch, not a hang
   task automatic wait_flag;
      int k;
      k = 0;
      while (rx_complete_flag !== 1'h1 && k < 3000) begin
         @(negedge clock);
         k++;
      end
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (tx_busy !== 1'h0 && k < 3000) begin
         @(negedge clock);
         k++;
      end
   endtask
   task automatic pop;
      data_read = 1'h1;
      @(negedge clock);
      data_read = 1'h0;
      wait_clk(3);
   endtask
   // frame: start, data lsb first, optional parity, stop, optional stop
   task automatic send(input logic [8:0] d, input logic [3:0] nb,
      input logic bad, input logic st1, input logic two);
      logic [15:0] b;
      logic [3:0] n;
      logic p;
      int i;
      b = 16'hFFFF;
      b[0] = 1'h0;
      p = cfg.parity_odd_select ^ bad;
      for (i = 0; i < nb; i++) begin
         b[i + 1] = d[i];
         p = p ^ d[i];
      end
      n = nb + 4'h1;
      if (cfg.parity_enable_bit) begin
         b[n] = p;
         n = n + 4'h1;
      end
      b[n] = st1;
      n = n + 4'h1 + {3'h0, two};
      wait_idle();
      bits = b;
      len = n;
      tpb = cfg.double_speed_select ? `URX_OSR_DOUBLE : `URX_OSR_NORMAL;
      go = 1'h1;
      @(negedge clock);
      go = 1'h0;
   endtask
   task automatic test_end(input string name);
      $display("test %s done", name);
   endtask
   task automatic end_sim;
      $display("counts: %0d compared, %0d bad", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      cfg.receiver_enable = 1'h1;
      cfg.char_size = 3'h3;
      wait_clk(10);
      rst = 1'h0;
      wait_clk(8);
      check_bit("flag", 1'h0, rx_complete_flag);
      check_bit("irq", 1'h0, rx_complete_irq);
      check_byte("data", 8'h00, serial_data_register);
      check_bit("override", 1'h1, rxd_override);
      test_end("reset");
      // short low pulses at both rates must be rejected as noise
      for (int s = 0; s < 2; s++) begin
         cfg.double_speed_select = s[0];
         wait_idle();
         bits = 16'hFFFE;
         len = 4'h1;
         tpb = s ? 5'h02 : 5'h03;
         go = 1'h1;
         @(negedge clock);
         go = 1'h0;
         wait_clk(200);
         check_bit("glitch", 1'h0, rx_complete_flag);
      end
      test_end("noise");
      foreach (rows[r]) begin
         cfg.double_speed_select = rows[r].dbl;
         cfg.parity_enable_bit = rows[r].pen;
         cfg.parity_odd_select = rows[r].odd;
         cfg.stop_bit_count_select = rows[r].two;
         cfg.char_size = rows[r].csz;
         send(rows[r].d, rows[r].csz == 3'h7 ? 4'h9 :
            {2'h0, rows[r].csz[1:0]} + 4'h5, rows[r].bad, rows[r].st1,
            rows[r].two);
         wait_flag();
         check_bit("flag", 1'h1, rx_complete_flag);
         check_byte("data", rows[r].x_data, serial_data_register);
         check_bit("ninth", rows[r].x_nin, received_ninth_bit);
         check_bit("fe", rows[r].x_fe, frame_error_flag);
         check_bit("pe", rows[r].x_pe, parity_error_flag);
         check_bit("ov", 1'h0, overrun_flag);
         pop();
         check_bit("flag", 1'h0, rx_complete_flag);
      end
      test_end("table");
      // four frames unread: two buffered, one held, the fourth is lost
      cfg = '0;
      cfg.receiver_enable = 1'h1;
      cfg.char_size = 3'h3;
      cfg.rx_complete_irq_enable = 1'h1;
      cfg.global_irq_enable = 1'h1;
      for (int f = 0; f < 4; f++) begin
         send(9'h011 * f[8:0] + 9'h011, 4'h8, 1'h0, 1'h1, 1'h0);
      end
      wait_idle();
      wait_clk(100);
      check_bit("irq", 1'h1, rx_complete_irq);
      cfg.global_irq_enable = 1'h0;
      wait_clk(2);
      check_bit("irq", 1'h0, rx_complete_irq);
      cfg.global_irq_enable = 1'h1;
      for (int f = 0; f < 3; f++) begin
         check_bit("flag", 1'h1, rx_complete_flag);
         check_byte("data", 8'h11 * f[7:0] + 8'h11, serial_data_register);
         check_bit("ov", f == 2, overrun_flag);
         pop();
      end
      check_bit("flag", 1'h0, rx_complete_flag);
      check_bit("irq", 1'h0, rx_complete_irq);
      send(9'h0E7, 4'h8, 1'h0, 1'h1, 1'h0);
      wait_flag();
      check_byte("data", 8'hE7, serial_data_register);
      check_bit("ov", 1'h0, overrun_flag);
      pop();
      test_end("overrun");
      // parity status follows the enable; then disable in mid-frame
      cfg.parity_enable_bit = 1'h1;
      send(9'h05A, 4'h8, 1'h1, 1'h1, 1'h0);
      wait_flag();
      check_bit("pe", 1'h1, parity_error_flag);
      cfg.parity_enable_bit = 1'h0;
      wait_clk(2);
      check_bit("pe", 1'h0, parity_error_flag);
      cfg.parity_enable_bit = 1'h1;
      send(9'h0C3, 4'h8, 1'h0, 1'h1, 1'h0);
      wait_clk(160);
      cfg.receiver_enable = 1'h0;
      wait_clk(1);
      check_bit("flag", 1'h0, rx_complete_flag);
      check_bit("override", 1'h0, rxd_override);
      wait_idle();
      cfg.receiver_enable = 1'h1;
      wait_clk(200);
      check_bit("flag", 1'h0, rx_complete_flag);
      test_end("disable");
      end_sim();
   end
endmodule
`default_nettype wire
